//--- src/adpc_pkg.sv
/*
 * Constants, types and field layout of the converter power and
 * volume-linking register bank.
 * Assumes a serial control port decoder on the same clock delivers
 * register reads and writes as single-cycle strobes.
 */
// ****************************************************************
// Function
// - Bit 15 one powers whole codec down
// - Bit 12 one enables headphone driver
// - Bit 10 one powers converter core down
// - Bit 8 one powers virtual ground down
// - Bit 6 reports core power-down completed
// - Bit 1 enables low frequency boost
// - Bit 0 enables de-emphasis filter
// - Link field 00: channels independent
// - Link 01: left uses right volume
// - Link 10: right uses left volume
// - Seven-bit volumes, left 14-8, right 6-0
// ****************************************************************
package adpc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0]  ADPC_VOLUME_OFS      = 8'h02;
	localparam logic [7:0]  ADPC_POWER_OFS       = 8'h05;
	localparam logic [7:0]  ADPC_CTRL3_OFS       = 8'h06;

	// Power control fields
	localparam int          ADPC_CODEC_PD_BIT    = 15;
	localparam int          ADPC_HP_DRV_BIT      = 12;
	localparam int          ADPC_CORE_PD_BIT     = 10;
	localparam int          ADPC_VIRTUAL_GROUND_AMP_PD_BIT     = 8;
	localparam int          ADPC_PD_DONE_BIT     = 6;
	localparam int          ADPC_BOOST_BIT       = 1;
	localparam int          ADPC_DEEMPH_BIT      = 0;
	// Reserved bits 14-13 = 01, 11/9/7 = 1, 5-2 = 1000
	localparam logic [15:0] ADPC_POWER_RSVD      = 16'h2AA0;

	// Volume and link fields
	localparam int          ADPC_VOL_W           = 7;
	localparam int          ADPC_LVOL_LSB        = 8;
	localparam int          ADPC_RVOL_LSB        = 0;
	localparam int          ADPC_LMUTE_BIT       = 15;
	localparam int          ADPC_RMUTE_BIT       = 7;
	localparam int          ADPC_LINK_LSB        = 14;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic        ADPC_CODEC_PD_RST    = 1'b1;
	localparam logic        ADPC_HP_DRV_RST      = 1'b0;
	localparam logic        ADPC_CORE_PD_RST     = 1'b1;
	localparam logic        ADPC_VIRTUAL_GROUND_AMP_PD_RST     = 1'b1;
	localparam logic        ADPC_BOOST_RST       = 1'b0;
	localparam logic        ADPC_DEEMPH_RST      = 1'b0;
	localparam logic [6:0]  ADPC_VOL_RST         = 7'h7F;
	localparam logic        ADPC_MUTE_RST        = 1'b1;

	// Core power-down settling time
	localparam int          ADPC_CLK_MHZ         = 125;
	localparam int          ADPC_PD_TIME_US      = 10;
	localparam int          ADPC_PD_CYCLES       = ADPC_PD_TIME_US * ADPC_CLK_MHZ;

	typedef enum logic [1:0]
	{
		ADPC_LINK_NONE  = 2'h0,
		ADPC_LINK_LEFT  = 2'h1,
		ADPC_LINK_RIGHT = 2'h2
	} adpc_link_t;

	typedef enum logic [2:0]
	{
		ADPC_CORE_UP   = 3'h1,
		ADPC_CORE_FALL = 3'h2,
		ADPC_CORE_DOWN = 3'h4
	} adpc_core_t;

	// Controls the rest of the converter acts upon
	typedef struct packed
	{
		logic       codec_powerdown;
		logic       headphone_driver_select;
		logic       converter_core_powerdown;
		logic       virtual_ground_powerdown;
		logic       low_freq_boost_enable;
		logic       deemphasis_enable;
	} adpc_power_t;

	typedef struct packed
	{
		logic       left_mute;
		logic [6:0] left_volume_level;
		logic       right_mute;
		logic [6:0] right_volume_level;
	} adpc_volume_t;

	typedef struct packed
	{
		adpc_power_t  pwr;
		adpc_volume_t vol;
		logic [1:0]   volume_link_select;
		adpc_core_t   core;
		logic [15:0]  pd_count;
		logic         core_powerdown_done_flag;
		logic [6:0]   left_volume_eff;
		logic [6:0]   right_volume_eff;
		logic [15:0]  rdata;
		logic         rvalid;
	} adpc_state_t;

endpackage : adpc_pkg

//--- src/adpc_regs.sv
/*
 * Power control, volume and volume-linking register bank with the
 * converter core power-down sequencer.
 * Assumes the serial control port decoder runs on clk and issues at
 * most one read or write strobe per cycle.
 */
`timescale 1ns/1ps
module adpc_regs
	import adpc_pkg::*;
#(
	parameter int PD_CYCLES = ADPC_PD_CYCLES
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Register access from the control port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	// Controls to the converter
	output adpc_power_t      power_ctrl,
	output logic             core_powerdown_done_flag,
	output logic             left_mute,
	output logic             right_mute,
	output logic      [6:0]  left_volume_level,
	output logic      [6:0]  right_volume_level
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [15:0] power_word(adpc_state_t s);
		logic [15:0] w;
		w = ADPC_POWER_RSVD;
		w[ADPC_CODEC_PD_BIT] = s.pwr.codec_powerdown;
		w[ADPC_HP_DRV_BIT]   = s.pwr.headphone_driver_select;
		w[ADPC_CORE_PD_BIT]  = s.pwr.converter_core_powerdown;
		w[ADPC_VIRTUAL_GROUND_AMP_PD_BIT]  = s.pwr.virtual_ground_powerdown;
		w[ADPC_PD_DONE_BIT]  = s.core_powerdown_done_flag;
		w[ADPC_BOOST_BIT]    = s.pwr.low_freq_boost_enable;
		w[ADPC_DEEMPH_BIT]   = s.pwr.deemphasis_enable;
		return w;
	endfunction : power_word

	adpc_state_t st;
	adpc_state_t next_st;

	localparam logic [15:0] PD_LAST = 16'(PD_CYCLES - 1);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_st = st;
		next_st.rvalid = 1'b0;
		if (reg_wr)
		begin
			case (reg_addr)
				ADPC_POWER_OFS:
				begin
					// Reserved and flag bits of the write are dropped
					next_st.pwr.codec_powerdown = reg_wdata[ADPC_CODEC_PD_BIT];
					next_st.pwr.headphone_driver_select = reg_wdata[ADPC_HP_DRV_BIT];
					next_st.pwr.converter_core_powerdown = reg_wdata[ADPC_CORE_PD_BIT];
					next_st.pwr.virtual_ground_powerdown = reg_wdata[ADPC_VIRTUAL_GROUND_AMP_PD_BIT];
					next_st.pwr.low_freq_boost_enable = reg_wdata[ADPC_BOOST_BIT];
					next_st.pwr.deemphasis_enable = reg_wdata[ADPC_DEEMPH_BIT];
				end
				ADPC_VOLUME_OFS:
				begin
					next_st.vol = reg_wdata;
				end
				ADPC_CTRL3_OFS:
				begin
					next_st.volume_link_select = reg_wdata[ADPC_LINK_LSB +: 2];
				end
				default:
				begin
					next_st.vol = st.vol;
				end
			endcase
		end
		if (reg_rd)
		begin
			next_st.rvalid = 1'b1;
			case (reg_addr)
				ADPC_POWER_OFS:  next_st.rdata = power_word(st);
				ADPC_VOLUME_OFS: next_st.rdata = st.vol;
				ADPC_CTRL3_OFS:  next_st.rdata = {st.volume_link_select, 14'h0000};
				default:         next_st.rdata = 16'h0000;
			endcase
		end

		// Core power-down sequencer: flag rises only after settling,
		// drops at once when the core is asked to power up
		case (st.core)
			ADPC_CORE_UP:
			begin
				if (st.pwr.converter_core_powerdown)
				begin
					next_st.core = ADPC_CORE_FALL;
					next_st.pd_count = 16'h0000;
				end
			end
			ADPC_CORE_FALL:
			begin
				if (!st.pwr.converter_core_powerdown)
					next_st.core = ADPC_CORE_UP;
				else if (st.pd_count == PD_LAST)
					next_st.core = ADPC_CORE_DOWN;
				else
					next_st.pd_count = st.pd_count + 16'h0001;
			end
			ADPC_CORE_DOWN:
			begin
				if (!st.pwr.converter_core_powerdown)
					next_st.core = ADPC_CORE_UP;
			end
			default:
			begin
				next_st.core = ADPC_CORE_DOWN;
			end
		endcase
		// Flag drops with the power-up write itself, never claiming a waking core
		next_st.core_powerdown_done_flag = (next_st.core == ADPC_CORE_DOWN)
			&& next_st.pwr.converter_core_powerdown;

		// Effective volumes; code 11 is undefined and kept independent
		next_st.left_volume_eff = st.vol.left_volume_level;
		next_st.right_volume_eff = st.vol.right_volume_level;
		if (st.volume_link_select == ADPC_LINK_LEFT)
			next_st.left_volume_eff = st.vol.right_volume_level;
		if (st.volume_link_select == ADPC_LINK_RIGHT)
			next_st.right_volume_eff = st.vol.left_volume_level;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '{
				pwr: '{ADPC_CODEC_PD_RST, ADPC_HP_DRV_RST, ADPC_CORE_PD_RST,
					ADPC_VIRTUAL_GROUND_AMP_PD_RST, ADPC_BOOST_RST, ADPC_DEEMPH_RST},
				vol: '{ADPC_MUTE_RST, ADPC_VOL_RST, ADPC_MUTE_RST, ADPC_VOL_RST},
				volume_link_select: ADPC_LINK_NONE,
				core: ADPC_CORE_DOWN,
				pd_count: 16'h0000,
				core_powerdown_done_flag: 1'b1,
				left_volume_eff: ADPC_VOL_RST,
				right_volume_eff: ADPC_VOL_RST,
				rdata: 16'h0000,
				rvalid: 1'b0
			};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;
	assign power_ctrl = st.pwr;
	assign core_powerdown_done_flag = st.core_powerdown_done_flag;
	assign left_mute = st.vol.left_mute;
	assign right_mute = st.vol.right_mute;
	assign left_volume_level = st.left_volume_eff;
	assign right_volume_level = st.right_volume_eff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence pwr_write_s(int b, logic v);
		reg_wr && reg_addr == ADPC_POWER_OFS && reg_wdata[b] == v;
	endsequence

	codec_pd_write_a: assert property (@(posedge clk) disable iff (!rstn)
		pwr_write_s(ADPC_CODEC_PD_BIT, 1'b0) |=> !power_ctrl.codec_powerdown)
		else $error("codec power-down did not follow write");
	hp_driver_write_a: assert property (@(posedge clk) disable iff (!rstn)
		pwr_write_s(ADPC_HP_DRV_BIT, 1'b1) |=> power_ctrl.headphone_driver_select)
		else $error("headphone driver select did not follow write");
	core_pd_write_a: assert property (@(posedge clk) disable iff (!rstn)
		pwr_write_s(ADPC_CORE_PD_BIT, 1'b1) |=> power_ctrl.converter_core_powerdown)
		else $error("core power-down did not follow write");
	virtual_ground_amp_pd_write_a: assert property (@(posedge clk) disable iff (!rstn)
		pwr_write_s(ADPC_VIRTUAL_GROUND_AMP_PD_BIT, 1'b0) |=> !power_ctrl.virtual_ground_powerdown)
		else $error("virtual ground power-down did not follow write");
	done_drops_a: assert property (@(posedge clk) disable iff (!rstn)
		$fell(power_ctrl.converter_core_powerdown) |=> !core_powerdown_done_flag)
		else $error("done flag stayed set after power-up");
	done_follows_a: assert property (@(posedge clk) disable iff (!rstn)
		$fell(power_ctrl.converter_core_powerdown) |-> !core_powerdown_done_flag)
		else $error("done flag outlived core power-up");
	done_needs_pd_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(core_powerdown_done_flag) |-> power_ctrl.converter_core_powerdown
		&& $past(power_ctrl.converter_core_powerdown))
		else $error("done flag rose without core power-down");
	filters_write_a: assert property (@(posedge clk) disable iff (!rstn)
		pwr_write_s(ADPC_BOOST_BIT, 1'b1) ##0 pwr_write_s(ADPC_DEEMPH_BIT, 1'b0)
		|=> power_ctrl.low_freq_boost_enable && !power_ctrl.deemphasis_enable)
		else $error("filter enables did not follow write");
	rsvd_read_a: assert property (@(posedge clk) disable iff (!rstn)
		reg_rd && reg_addr == ADPC_POWER_OFS |=> reg_rvalid
		&& (reg_rdata & 16'h6ABC) == ADPC_POWER_RSVD)
		else $error("reserved power bits read wrong");
	volume_write_a: assert property (@(posedge clk) disable iff (!rstn)
		reg_wr && reg_addr == ADPC_VOLUME_OFS |=> st.vol == $past(reg_wdata))
		else $error("volume register did not follow write");
	link_left_a: assert property (@(posedge clk) disable iff (!rstn)
		st.volume_link_select == ADPC_LINK_LEFT |=>
		left_volume_level == $past(st.vol.right_volume_level))
		else $error("left channel not linked to right volume");
	link_right_a: assert property (@(posedge clk) disable iff (!rstn)
		st.volume_link_select == ADPC_LINK_RIGHT |=>
		right_volume_level == $past(st.vol.left_volume_level))
		else $error("right channel not linked to left volume");
	link_none_a: assert property (@(posedge clk) disable iff (!rstn)
		st.volume_link_select == ADPC_LINK_NONE |=>
		left_volume_level == $past(st.vol.left_volume_level)
		&& right_volume_level == $past(st.vol.right_volume_level))
		else $error("independent volumes not kept");

endmodule : adpc_regs

//--- verification/test_audio_dac_power_config_regs.sv
/*
 * Self-checking bench for the converter power and volume-linking registers.
 * Assumes the register bank alone, driven straight through its strobe ports.
 */
`timescale 1ns/1ps
module test_audio_dac_power_config_regs;
	import adpc_pkg::*;

	// ****************************************************************
	// Stimulus and observation
	// ****************************************************************
	// Short settling count keeps the done-flag waits brief
	localparam int PD = 4;
	logic        clk       = 1'b0;
	logic        rstn      = 1'b0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic        reg_rvalid;
	adpc_power_t power_ctrl;
	logic        done_flag;
	logic        left_mute;
	logic        right_mute;
	logic [6:0]  left_volume_level;
	logic [6:0]  right_volume_level;
	int          seed        = 33;
	int          fail_count  = 0;
	int          checks_done = 0;
	int          cyc         = 0;

	adpc_regs #(.PD_CYCLES(PD)) adpc_regs_i
	(
		.clk                      (clk),
		.rstn                     (rstn),
		.reg_wr                   (reg_wr),
		.reg_rd                   (reg_rd),
		.reg_addr                 (reg_addr),
		.reg_wdata                (reg_wdata),
		.reg_rdata                (reg_rdata),
		.reg_rvalid               (reg_rvalid),
		.power_ctrl               (power_ctrl),
		.core_powerdown_done_flag (done_flag),
		.left_mute                (left_mute),
		.right_mute               (right_mute),
		.left_volume_level        (left_volume_level),
		.right_volume_level       (right_volume_level)
	);

	always #4 clk = ~clk;

	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			test_done();
		end
	end

	// ****************************************************************
	// Tasks and expectations
	// ****************************************************************
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr

	// Valid must stand exactly one cycle after the taking edge
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		chk({15'h0000, reg_rvalid}, 16'h0001);
		d = reg_rdata;
		@(posedge clk);
		#1;
		chk({15'h0000, reg_rvalid}, 16'h0000);
	endtask : rd

	function automatic logic [15:0] exp_pwr(input logic [15:0] d, input logic dn);
		return 16'h2AA0 | (d & 16'h9503) | {9'h000, dn, 6'h00};
	endfunction : exp_pwr

	function automatic logic [15:0] pbits(input logic [15:0] d);
		return {10'h000, d[15], d[12], d[10], d[8], d[1], d[0]};
	endfunction : pbits

	task test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		logic [15:0] r;
		logic [15:0] d;
		logic [15:0] p;
		logic [6:0]  el;
		logic [6:0]  er;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd(ADPC_POWER_OFS, r);
		chk(r, 16'hAFE0);
		chk({10'h000, power_ctrl}, 16'h002C);
		rd(ADPC_CTRL3_OFS, r);
		chk(r, 16'h0000);
		$display("reset values done");

		wr(ADPC_POWER_OFS, 16'h2AA0);
		#1;
		chk({15'h0000, done_flag}, 16'h0000);
		wr(ADPC_POWER_OFS, 16'h2EA0);
		repeat (PD - 1) @(posedge clk);
		#1;
		chk({15'h0000, done_flag}, 16'h0000);
		@(posedge clk) #1;
		chk({15'h0000, done_flag}, 16'h0000);
		@(posedge clk) #1;
		chk({15'h0000, done_flag}, 16'h0001);
		$display("power-down sequence done");

		for (int k = 0; k < 10; k++)
		begin
			d = 16'($random(seed));
			if (k < 5)
				d = (d & 16'h9503) | 16'h2AA0;
			wr(ADPC_POWER_OFS, d);
			repeat (PD + 4) @(posedge clk);
			rd(ADPC_POWER_OFS, r);
			chk(r, exp_pwr(d, d[10]));
			chk({10'h000, power_ctrl}, pbits(d));
		end
		$display("power writes done");

		for (int k = 0; k < 8; k++)
		begin
			d = 16'($random(seed));
			p = 16'($random(seed));
			p[15:14] = k[1:0];
			wr(ADPC_VOLUME_OFS, d);
			wr(ADPC_CTRL3_OFS, p);
			repeat (2) @(posedge clk);
			#1;
			el = d[14:8];
			er = d[6:0];
			if (k[1:0] == 2'h1)
				el = er;
			if (k[1:0] == 2'h2)
				er = el;
			chk({2'h0, left_volume_level, right_volume_level}, {2'h0, el, er});
			chk({14'h0000, left_mute, right_mute}, {14'h0000, d[15], d[7]});
			rd(ADPC_VOLUME_OFS, r);
			chk(r, d);
			rd(ADPC_CTRL3_OFS, r);
			chk(r, {p[15:14], 14'h0000});
		end
		$display("volume linking done");

		rd(ADPC_POWER_OFS, p);
		wr(8'h03, 16'($random(seed)));
		rd(8'h03, r);
		chk(r, 16'h0000);
		rd(ADPC_POWER_OFS, r);
		chk(r, p);
		$display("unmapped access done");

		// Mid-run reset must bring back every reset value
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(ADPC_POWER_OFS, r);
		chk(r, 16'hAFE0);
		chk({10'h000, power_ctrl}, 16'h002C);
		rd(ADPC_VOLUME_OFS, r);
		chk(r, 16'hFFFF);
		rd(ADPC_CTRL3_OFS, r);
		chk(r, 16'h0000);
		$display("mid-run reset done");
		test_done();
	end

endmodule : test_audio_dac_power_config_regs
